// file: shared/crtcsv_pkg.sv
// Package: constants shared by the split-screen / vertical-total block.
// Assumes a single 200 MHz clock, a synchronous active-low reset, and a host
// that reaches the registers through an indexed pair of I/O ports.
package crtcsv_pkg;

  // ----------------------------------------------------------------------
  // i/o ports (index / data, mono and colour)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IO_MONO_INDEX = 16'h03B4;
  localparam logic [15:0] IO_MONO_DATA = 16'h03B5;
  localparam logic [15:0] IO_COLOR_INDEX = 16'h03D4;
  localparam logic [15:0] IO_COLOR_DATA = 16'h03D5;

  // ----------------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_VTOTAL_LOW = 8'h06;
  localparam logic [7:0] IDX_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_MAX_SCAN = 8'h09;
  localparam logic [7:0] IDX_START_HIGH = 8'h0C;
  localparam logic [7:0] IDX_START_LOW = 8'h0D;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h17;
  localparam logic [7:0] IDX_LINE_CMP_LOW = 8'h18;
  localparam logic [7:0] IDX_READ_LATCH = 8'h22;
  localparam logic [7:0] IDX_EXT_VTOTAL = 8'h30;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int MODE_SUB13_BIT = 0;
  localparam int MODE_SUB14_BIT = 1;
  localparam int MAX_SCAN_LC9_BIT = 6;
  localparam int OVF_LC8_BIT = 4;
  localparam int OVF_VT9_BIT = 5;
  localparam int OVF_VT8_BIT = 0;
  localparam int SUB13_ADDR_BIT = 13;
  localparam int SUB14_ADDR_BIT = 14;
  localparam logic [7:0] EXT_VT_MASK = 8'h0F;
  localparam logic [7:0] MAX_SCAN_ROWS_MASK = 8'h1F;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] RST_VTOTAL_LOW = 8'h00;
  localparam logic [7:0] RST_OVERFLOW = 8'h00;
  localparam logic [7:0] RST_MAX_SCAN = 8'h00;
  localparam logic [7:0] RST_START_HIGH = 8'h00;
  localparam logic [7:0] RST_START_LOW = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_LINE_CMP_LOW = 8'h00;
  localparam logic [7:0] RST_EXT_VTOTAL = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [11:0] RST_LINE = 12'h000;
  localparam logic [4:0] RST_ROW = 5'h00;

endpackage : crtcsv_pkg

// file: rtl/crtcsv_addr_subst.sv
// Address substitution stage in front of the frame buffer decoder.
// Assumes the reorganized address and the row-scan count are stable in
// the same cycle; purely combinational.
`timescale 1ns/1ps
module crtcsv_addr_subst (
  input wire logic [15:0] reorganized_addr_bit, // reshuffled refresh address
  input wire logic [1:0] row_scan_bits, // row-scan bits 1 and 0
  input wire logic [7:0] mode_ctrl, // crt mode control register
  output logic [15:0] fb_decoder_input_bit // address to frame buffer decoder
);
  import crtcsv_pkg::*;

  logic sub13;
  logic sub14;

  assign sub13 = ~mode_ctrl[MODE_SUB13_BIT];
  assign sub14 = ~mode_ctrl[MODE_SUB14_BIT];

  always_comb begin
    fb_decoder_input_bit = reorganized_addr_bit;
    if (sub13) begin
      fb_decoder_input_bit[SUB13_ADDR_BIT] = row_scan_bits[0];
    end
    if (sub14) begin
      fb_decoder_input_bit[SUB14_ADDR_BIT] = row_scan_bits[1];
    end
  end

endmodule : crtcsv_addr_subst

// file: rtl/crtcsv_vtime_sel.sv
// Forms the vertical total and the line compare value from the registers.
// Assumes register values come from flip-flops on the same clock.
`timescale 1ns/1ps
module crtcsv_vtime_sel (
  input wire logic [7:0] vtotal_low, // vertical total low byte
  input wire logic [7:0] overflow, // overflow register
  input wire logic [7:0] max_scan, // maximum scan line register
  input wire logic [7:0] line_cmp_low, // line compare low byte
  input wire logic [7:0] ext_vtotal, // extended vertical total register
  input wire logic ext_mode, // extended-mode control bit 0
  output logic [11:0] vtotal, // programmed vertical total
  output logic [9:0] line_cmp // 10-bit line compare value
);
  import crtcsv_pkg::*;

  logic [11:0] vtotal_std;
  logic [11:0] vtotal_ext;

  assign vtotal_std = {2'b00, overflow[OVF_VT9_BIT], overflow[OVF_VT8_BIT], vtotal_low};
  assign vtotal_ext = {ext_vtotal[3:0], vtotal_low};
  // extended bits unused in standard mode
  assign vtotal = ext_mode ? vtotal_ext : vtotal_std;

  assign line_cmp = {max_scan[MAX_SCAN_LC9_BIT], overflow[OVF_LC8_BIT], line_cmp_low};

endmodule : crtcsv_vtime_sel

// file: rtl/crtcsv_top.sv
// Top of the split-screen / vertical-total slice of the display controller.
// Assumes LINE_START and CHAR_TICK are one-cycle pulses from the horizontal
// timing logic on CLK, and that the byte/word reshuffle stage sits outside,
// taking REFRESH_ADDR and returning REORG_ADDR in the same cycle.
`timescale 1ns/1ps
module crtcsv_top (
  input wire logic CLK, // 200 MHz clock
  input wire logic RSTN, // synchronous reset, active low
  input wire logic [15:0] IO_ADDR, // host i/o address
  input wire logic IO_WR, // host write strobe, one cycle
  input wire logic IO_RD, // host read strobe, one cycle
  input wire logic [7:0] IO_WDATA, // host write data
  input wire logic MONO_SEL, // 1 selects mono port pair, 0 colour pair
  input wire logic EXT_MODE, // extended-mode control bit 0
  input wire logic [1:0] READ_MAP_SEL, // read map select bits 1 and 0
  input wire logic [7:0] LATCH0, // memory read latch 0
  input wire logic [7:0] LATCH1, // memory read latch 1
  input wire logic [7:0] LATCH2, // memory read latch 2
  input wire logic [7:0] LATCH3, // memory read latch 3
  input wire logic LINE_START, // pulse at start of each horizontal line
  input wire logic CHAR_TICK, // pulse per character fetch
  input wire logic [7:0] LINE_PITCH, // address step per character row
  input wire logic [15:0] REORG_ADDR, // reshuffled refresh address
  output logic [7:0] IO_RDATA, // host read data
  output logic IO_RVALID, // read data valid, one cycle
  output logic [15:0] REFRESH_ADDR, // refresh memory address counter
  output logic [15:0] FB_ADDR, // address to frame buffer decoder
  output logic [11:0] SCAN_LINE, // current vertical scan line
  output logic [4:0] ROW_SCAN, // row scan counter
  output logic FRAME_START, // pulse on first line of a frame
  output logic SPLIT_ACTIVE // high from line compare to frame end
);
  import crtcsv_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic port_hit(input logic [15:0] addr, input logic mono,
                                    input logic [15:0] mono_port,
                                    input logic [15:0] color_port);
    port_hit = mono ? (addr == mono_port) : (addr == color_port);
  endfunction : port_hit

  function automatic logic [15:0] add_pitch(input logic [15:0] base,
                                            input logic [7:0] pitch);
    add_pitch = base + {8'h00, pitch};
  endfunction : add_pitch

  // ----------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------
  logic [7:0] index_reg;
  logic [7:0] index_next;
  logic [7:0] vertical_total_low_reg;
  logic [7:0] overflow_reg;
  logic [7:0] max_scan_line_reg;
  logic [7:0] start_address_high_reg;
  logic [7:0] start_address_low_reg;
  logic [7:0] crt_mode_control_reg;
  logic [7:0] split_line_compare_low_reg;
  logic [7:0] ext_vertical_total_high_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;

  // ----------------------------------------------------------------------
  // indexed port decode
  // ----------------------------------------------------------------------
  logic index_hit;
  logic data_hit;
  logic index_wr;
  logic data_wr;
  logic wr_vtotal_low;
  logic wr_overflow;
  logic wr_max_scan;
  logic wr_start_high;
  logic wr_start_low;
  logic wr_mode_ctrl;
  logic wr_line_cmp;
  logic wr_ext_vtotal;

  assign index_hit = port_hit(IO_ADDR, MONO_SEL, IO_MONO_INDEX, IO_COLOR_INDEX);
  assign data_hit = port_hit(IO_ADDR, MONO_SEL, IO_MONO_DATA, IO_COLOR_DATA);
  assign index_wr = IO_WR & index_hit;
  assign data_wr = IO_WR & data_hit;
  assign index_next = index_wr ? IO_WDATA : index_reg;

  assign wr_vtotal_low = data_wr & (index_reg == IDX_VTOTAL_LOW);
  assign wr_overflow = data_wr & (index_reg == IDX_OVERFLOW);
  assign wr_max_scan = data_wr & (index_reg == IDX_MAX_SCAN);
  assign wr_start_high = data_wr & (index_reg == IDX_START_HIGH);
  assign wr_start_low = data_wr & (index_reg == IDX_START_LOW);
  assign wr_mode_ctrl = data_wr & (index_reg == IDX_MODE_CTRL);
  assign wr_line_cmp = data_wr & (index_reg == IDX_LINE_CMP_LOW);
  assign wr_ext_vtotal = data_wr & (index_reg == IDX_EXT_VTOTAL);

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [7:0] latch_view;
  logic [7:0] data_view;

  assign latch_view = (READ_MAP_SEL == 2'b00) ? LATCH0 :
                      (READ_MAP_SEL == 2'b01) ? LATCH1 :
                      (READ_MAP_SEL == 2'b10) ? LATCH2 : LATCH3;

  always_comb begin
    if (index_reg == IDX_VTOTAL_LOW) begin
      data_view = vertical_total_low_reg;
    end else if (index_reg == IDX_OVERFLOW) begin
      data_view = overflow_reg;
    end else if (index_reg == IDX_MAX_SCAN) begin
      data_view = max_scan_line_reg;
    end else if (index_reg == IDX_START_HIGH) begin
      data_view = start_address_high_reg;
    end else if (index_reg == IDX_START_LOW) begin
      data_view = start_address_low_reg;
    end else if (index_reg == IDX_MODE_CTRL) begin
      data_view = crt_mode_control_reg;
    end else if (index_reg == IDX_LINE_CMP_LOW) begin
      data_view = split_line_compare_low_reg;
    end else if (index_reg == IDX_READ_LATCH) begin
      data_view = latch_view;
    end else if (index_reg == IDX_EXT_VTOTAL) begin
      data_view = ext_vertical_total_high_reg;
    end else begin
      data_view = UNMAPPED_READ;
    end
  end

  assign rdata_next = (IO_RD & index_hit) ? index_reg :
                      (IO_RD & data_hit) ? data_view : rdata_reg;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // no write path to the latch view
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      index_reg <= RST_INDEX;
      vertical_total_low_reg <= RST_VTOTAL_LOW;
      overflow_reg <= RST_OVERFLOW;
      max_scan_line_reg <= RST_MAX_SCAN;
      start_address_high_reg <= RST_START_HIGH;
      start_address_low_reg <= RST_START_LOW;
      crt_mode_control_reg <= RST_MODE_CTRL;
      split_line_compare_low_reg <= RST_LINE_CMP_LOW;
      ext_vertical_total_high_reg <= RST_EXT_VTOTAL;
    end else begin
      index_reg <= index_next;
      if (wr_vtotal_low) vertical_total_low_reg <= IO_WDATA;
      if (wr_overflow) overflow_reg <= IO_WDATA;
      if (wr_max_scan) max_scan_line_reg <= IO_WDATA;
      if (wr_start_high) start_address_high_reg <= IO_WDATA;
      if (wr_start_low) start_address_low_reg <= IO_WDATA;
      if (wr_mode_ctrl) crt_mode_control_reg <= IO_WDATA;
      if (wr_line_cmp) split_line_compare_low_reg <= IO_WDATA;
      // reserved bits not stored, read as zero
      if (wr_ext_vtotal) ext_vertical_total_high_reg <= IO_WDATA & EXT_VT_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_reg <= UNMAPPED_READ;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= IO_RD & (index_hit | data_hit);
    end
  end

  // ----------------------------------------------------------------------
  // vertical total and line compare
  // ----------------------------------------------------------------------
  logic [11:0] vtotal;
  logic [9:0] line_cmp;

  crtcsv_vtime_sel u_vtime_sel (
    .vtotal_low(vertical_total_low_reg),
    .overflow(overflow_reg),
    .max_scan(max_scan_line_reg),
    .line_cmp_low(split_line_compare_low_reg),
    .ext_vtotal(ext_vertical_total_high_reg),
    .ext_mode(EXT_MODE),
    .vtotal(vtotal),
    .line_cmp(line_cmp)
  );

  // ----------------------------------------------------------------------
  // vertical line and row-scan counters
  // ----------------------------------------------------------------------
  logic [11:0] line_reg;
  logic [11:0] line_next;
  logic [4:0] row_reg;
  logic [4:0] row_next;
  logic [15:0] row_base_reg;
  logic [15:0] row_base_next;
  logic [15:0] ma_reg;
  logic [15:0] ma_next;
  logic [15:0] start_addr;
  logic [11:0] last_line;
  logic [11:0] line_inc;
  logic at_last;
  logic new_frame;
  logic cmp_hit;
  logic row_wrap;
  logic split_reg;
  logic split_next;
  logic frame_reg;

  assign start_addr = {start_address_high_reg, start_address_low_reg};
  // frame holds total plus two lines
  assign last_line = vtotal + 12'h001;
  assign line_inc = line_reg + 12'h001;
  assign at_last = (line_reg == last_line);
  // every line counted, active or not
  assign line_next = !LINE_START ? line_reg : (at_last ? RST_LINE : line_inc);
  assign new_frame = LINE_START & at_last;
  assign cmp_hit = LINE_START & !at_last & (line_inc == {2'b00, line_cmp});
  assign row_wrap = (row_reg == max_scan_line_reg[4:0]);

  always_comb begin
    row_base_next = row_base_reg;
    row_next = row_reg;
    split_next = split_reg;
    if (new_frame) begin
      row_base_next = start_addr;
      row_next = RST_ROW;
      split_next = 1'b0;
    end else if (cmp_hit) begin
      row_base_next = RST_ADDR;
      row_next = RST_ROW;
      split_next = 1'b1;
    end else if (LINE_START) begin
      if (row_wrap) begin
        row_base_next = add_pitch(row_base_reg, LINE_PITCH);
        row_next = RST_ROW;
      end else begin
        row_next = row_reg + 5'h01;
      end
    end
  end

  assign ma_next = LINE_START ? row_base_next :
                   CHAR_TICK ? ma_reg + 16'h0001 : ma_reg;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      line_reg <= RST_LINE;
      row_reg <= RST_ROW;
      row_base_reg <= RST_ADDR;
      ma_reg <= RST_ADDR;
      split_reg <= 1'b0;
      frame_reg <= 1'b0;
    end else begin
      line_reg <= line_next;
      row_reg <= row_next;
      row_base_reg <= row_base_next;
      ma_reg <= ma_next;
      split_reg <= split_next;
      frame_reg <= new_frame;
    end
  end

  // ----------------------------------------------------------------------
  // address substitution and outputs
  // ----------------------------------------------------------------------
  logic [15:0] fb_addr_comb;
  logic [15:0] fb_addr_reg;

  crtcsv_addr_subst u_addr_subst (
    .reorganized_addr_bit(REORG_ADDR),
    .row_scan_bits(row_reg[1:0]),
    .mode_ctrl(crt_mode_control_reg),
    .fb_decoder_input_bit(fb_addr_comb)
  );

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      fb_addr_reg <= RST_ADDR;
    end else begin
      fb_addr_reg <= fb_addr_comb;
    end
  end

  assign IO_RDATA = rdata_reg;
  assign IO_RVALID = rvalid_reg;
  assign REFRESH_ADDR = ma_reg;
  assign FB_ADDR = fb_addr_reg;
  assign SCAN_LINE = line_reg;
  assign ROW_SCAN = row_reg;
  assign FRAME_START = frame_reg;
  assign SPLIT_ACTIVE = split_reg;

endmodule : crtcsv_top

// file: dv/crtcsv_monitor.sv
// checker: port-level timing relations of the split-screen block
// assumes it is bound onto every crtcsv_top instance
`timescale 1ns/1ps
module crtcsv_monitor (
  input wire logic CLK, // clock
  input wire logic RSTN, // sync reset, active low
  input wire logic IO_RD, // host read strobe
  input wire logic LINE_START, // line start pulse
  input wire logic CHAR_TICK, // character pulse
  input wire logic [15:0] REORG_ADDR, // reshuffled address
  input wire logic [7:0] IO_RDATA, // read data
  input wire logic IO_RVALID, // read valid
  input wire logic [15:0] REFRESH_ADDR, // refresh counter
  input wire logic [15:0] FB_ADDR, // decoder address
  input wire logic [11:0] SCAN_LINE, // scan line
  input wire logic [4:0] ROW_SCAN, // row scan
  input wire logic FRAME_START, // frame pulse
  input wire logic SPLIT_ACTIVE // split flag
);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_rvalid_cause: assert property (IO_RVALID |-> $past(IO_RD))
    else $error("read valid without a read strobe");
  a_rdata_hold: assert property ($past(RSTN) && !IO_RVALID |-> $stable(IO_RDATA))
    else $error("read data moved without read valid");
  a_fb_pass_through: assert property ($past(RSTN) |-> FB_ADDR[12:0] == $past(REORG_ADDR[12:0])
    && FB_ADDR[15] == $past(REORG_ADDR[15]))
    else $error("unsubstituted address bits altered");
  a_frame_wrap_state: assert property (FRAME_START |-> SCAN_LINE == 12'h000
    && ROW_SCAN == 5'h00 && !SPLIT_ACTIVE)
    else $error("frame start without counters cleared");
  a_frame_pulse_cause: assert property (FRAME_START |-> $past(LINE_START) ##1 !FRAME_START)
    else $error("frame start not a single pulse after line start");
  a_split_reload: assert property ($past(RSTN) && $rose(SPLIT_ACTIVE) |->
    REFRESH_ADDR == 16'h0000 && ROW_SCAN == 5'h00 && $past(LINE_START))
    else $error("split entry without address reload");
  a_split_clear_wrap: assert property ($past(RSTN) && $fell(SPLIT_ACTIVE) |-> FRAME_START)
    else $error("split cleared outside frame wrap");
  a_line_step: assert property ($past(RSTN) && $changed(SCAN_LINE) |-> $past(LINE_START)
    && (SCAN_LINE == $past(SCAN_LINE) + 12'h001 || SCAN_LINE == 12'h000))
    else $error("scan line jumped");
  a_addr_still: assert property ($past(RSTN) && !$past(LINE_START) && !$past(CHAR_TICK)
    |-> $stable(REFRESH_ADDR))
    else $error("refresh address moved without a tick");

  c_frame: cover property (FRAME_START);
  c_split: cover property ($rose(SPLIT_ACTIVE));
  c_read: cover property (IO_RVALID);
endmodule : crtcsv_monitor

bind crtcsv_top crtcsv_monitor u_monitor (.*);

// file: dv/crtcsv_fb_model.sv
// far side: byte-mode reshuffle stage and the four memory read latches
// assumes the counter address is looped back in the same cycle
`timescale 1ns/1ps
module crtcsv_fb_model #(
  parameter logic [7:0] L0 = 8'hC1,
  parameter logic [7:0] L1 = 8'h5E,
  parameter logic [7:0] L2 = 8'h3A,
  parameter logic [7:0] L3 = 8'h96
) (
  input wire logic [15:0] refresh_addr, // counter output
  output logic [15:0] reorg_addr, // reshuffled address
  output logic [7:0] latch0, // read latch 0
  output logic [7:0] latch1, // read latch 1
  output logic [7:0] latch2, // read latch 2
  output logic [7:0] latch3 // read latch 3
);
  assign reorg_addr = refresh_addr;
  assign latch0 = L0;
  assign latch1 = L1;
  assign latch2 = L2;
  assign latch3 = L3;
endmodule : crtcsv_fb_model

// file: dv/tb_crtc_split_vtotal_addr_sub.sv
// testbench: register access, split screen, frame length and substitution
// assumes the package constants and a byte-mode far-side model
`timescale 1ns/1ps
module tb_crtc_split_vtotal_addr_sub;
  import crtcsv_pkg::*;
  localparam logic [7:0] LAT [4] = '{8'hC1, 8'h5E, 8'h3A, 8'h96};
  logic CLK, RSTN, IO_WR, IO_RD, MONO_SEL, EXT_MODE, LINE_START, CHAR_TICK;
  logic [15:0] IO_ADDR, REORG_ADDR, REFRESH_ADDR, FB_ADDR, e;
  logic [7:0] IO_WDATA, LATCH0, LATCH1, LATCH2, LATCH3, LINE_PITCH, IO_RDATA, d;
  logic [1:0] READ_MAP_SEL;
  logic [11:0] SCAN_LINE;
  logic [4:0] ROW_SCAN;
  logic IO_RVALID, FRAME_START, SPLIT_ACTIVE, rv, fs;
  int bad_count, samples_checked, cycles, n;
  logic [23:0] rows [10] = '{24'h065A5A, 24'h073131, 24'h090303, 24'h0C7F7F, 24'h0DFFFF,
    24'h170303, 24'h18A5A5, 24'h300F0F, {16'h2211, LAT[2]}, 24'h55AA00};

  crtcsv_top DUT (.*);
  crtcsv_fb_model #(.L0(LAT[0]), .L1(LAT[1]), .L2(LAT[2]), .L3(LAT[3])) fbm (
    .refresh_addr(REFRESH_ADDR), .reorg_addr(REORG_ADDR), .latch0(LATCH0),
    .latch1(LATCH1), .latch2(LATCH2), .latch3(LATCH3));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
    samples_checked++;
    if (sn !== ex) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  function automatic logic [15:0] port(input logic dat);
    return (MONO_SEL ? IO_MONO_INDEX : IO_COLOR_INDEX) + {15'h0000, dat};
  endfunction : port

  // one strobe, answer taken one cycle later, then one idle cycle
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] wd);
    IO_ADDR = a;
    IO_WDATA = wd;
    IO_WR = wr;
    IO_RD = !wr;
    @(negedge CLK);
    IO_WR = 0;
    IO_RD = 0;
    rv = IO_RVALID;
    d = IO_RDATA;
    @(negedge CLK);
  endtask : acc

  task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
    acc(1, port(0), i);
    acc(1, port(1), v);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] i);
    acc(1, port(0), i);
    acc(0, port(1), 8'h00);
    chk("read valid", 16'h0001, {15'h0000, rv});
  endtask : reg_rd

  task automatic line_pulse();
    LINE_START = 1;
    @(negedge CLK);
    LINE_START = 0;
    fs = FRAME_START;
    @(negedge CLK);
  endtask : line_pulse

  task automatic run_frame();
    n = 0;
    fs = 0;
    while (!fs && n < 5000) begin
      line_pulse();
      n++;
    end
  endtask : run_frame

  // ----------------------------------------------------------------------
  // clock, timeout, sequence
  // ----------------------------------------------------------------------
  initial begin
    CLK = 0;
    forever #2.5 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 12000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    RSTN = 0;
    IO_WR = 0;
    IO_RD = 0;
    IO_ADDR = 16'h0000;
    IO_WDATA = 8'h00;
    MONO_SEL = 0;
    EXT_MODE = 0;
    READ_MAP_SEL = 2'h2;
    LINE_START = 0;
    CHAR_TICK = 0;
    LINE_PITCH = 8'h00;
    repeat (4) @(negedge CLK);
    RSTN = 1;
    chk("scan line", 16'h0000, {4'h0, SCAN_LINE});
    reg_rd(IDX_EXT_VTOTAL);
    chk("ext total reset", 16'h0000, {8'h00, d});
    foreach (rows[k]) begin
      reg_wr(rows[k][23:16], rows[k][15:8]);
      reg_rd(rows[k][23:16]);
      chk("register", {8'h00, rows[k][7:0]}, {8'h00, d});
    end
    for (int s = 0; s < 4; s++) begin
      READ_MAP_SEL = s[1:0];
      reg_rd(IDX_READ_LATCH);
      chk("latch view", {8'h00, LAT[s]}, {8'h00, d});
    end
    MONO_SEL = 1;
    reg_rd(IDX_LINE_CMP_LOW);
    chk("mono pair", 16'h00A5, {8'h00, d});
    acc(0, IO_COLOR_DATA, 8'h00);
    chk("inactive pair", 16'h0000, {15'h0000, rv});
    acc(0, port(0), 8'h00);
    chk("index read", {8'h00, IDX_LINE_CMP_LOW}, {8'h00, d});
    MONO_SEL = 0;
    // split at line 0x1A5 from overflow bit4 and the compare low byte
    repeat (420) line_pulse();
    chk("split early", 16'h0000, {15'h0000, SPLIT_ACTIVE});
    line_pulse();
    chk("split", 16'h0001, {15'h0000, SPLIT_ACTIVE});
    chk("split addr", 16'h0000, REFRESH_ADDR);
    chk("split line", 16'h01A5, {4'h0, SCAN_LINE});
    // standard total 0x35A: wrap after line 0x35B, ext bits ignored
    run_frame();
    chk("std frame", 16'd439, n[15:0]);
    chk("start addr", 16'h7FFF, REFRESH_ADDR);
    for (int r = 0; r < 3; r++) begin
      for (int m = 0; m < 4; m++) begin
        reg_wr(IDX_MODE_CTRL, m[7:0]);
        e = 16'h7FFF;
        if (!m[0]) e[13] = r[0];
        if (!m[1]) e[14] = r[1];
        chk("fb addr", e, FB_ADDR);
      end
      line_pulse();
    end
    run_frame();
    EXT_MODE = 1;
    reg_wr(IDX_EXT_VTOTAL, 8'h01);
    run_frame();
    chk("ext frame", 16'd348, n[15:0]);
    // character tick and row pitch step from the start address base
    LINE_PITCH = 8'h50;
    CHAR_TICK = 1;
    @(negedge CLK);
    CHAR_TICK = 0;
    chk("char tick", 16'h8000, REFRESH_ADDR);
    repeat (3) line_pulse();
    chk("row scan", 16'h0003, {11'h000, ROW_SCAN});
    chk("row base", 16'h7FFF, REFRESH_ADDR);
    line_pulse();
    chk("row wrap", 16'h0000, {11'h000, ROW_SCAN});
    chk("pitch step", 16'h804F, REFRESH_ADDR);
    // reset in mid-run clears counters and registers
    RSTN = 0;
    @(negedge CLK);
    RSTN = 1;
    chk("reset addr", 16'h0000, REFRESH_ADDR);
    chk("reset line", 16'h0000, {4'h0, SCAN_LINE});
    reg_rd(IDX_VTOTAL_LOW);
    chk("reset reg", 16'h0000, {8'h00, d});
    close_out();
  end
endmodule : tb_crtc_split_vtotal_addr_sub
